// >>> core/sbsr_pkg.sv
// constants for the synchronous pipelined burst static ram
package sbsr_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 18;
    localparam int WORDS = 32768;
    localparam int BURST_W = 2;
    localparam int LOW_LANE_LSB = 0;
    localparam int LOW_LANE_MSB = 8;
    localparam int HIGH_LANE_LSB = 9;
    localparam int HIGH_LANE_MSB = 17;
    localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_CNT_STEP = 2'h1;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
endpackage : sbsr_pkg

// >>> core/sbsr_top.sv
// synchronous pipelined burst static ram, 32768 x 18, with burst counter
//
// Behaviour
// - array holds 32768 words of 18 bits, 15-bit address, common data bus
// - address, data and all controls except output enable registered
// - read data goes through output register, valid after the second edge following the request
// - output enable combinational; writes and deselect keep outputs floating
// - write starts on clock edge, timed internally without external pulse
// - low byte enable gates bits 0-8, high byte enable bits 9-17
// - processor strobe low with select: load address, read, ignore writes
// - processor strobe needs select; controller strobe unselected deselects
// - controller strobe low, processor high, selected: load, write or read
// - chip select only matters in cycles loading a new base address
// - burst step low advances address before that cycle's access
// - strobes and burst step high repeat current address as wait state
// - only two low address bits counted, wrapping after four accesses
// - data outputs float from power-up until an enabled read
`timescale 1ns/100ps
module sbsr_top #(
    parameter int ADDR_W = sbsr_pkg::ADDR_W,
    parameter int DATA_W = sbsr_pkg::DATA_W,
    parameter int WORDS = sbsr_pkg::WORDS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // address and strobes
    input wire logic [ADDR_W-1:0] i_addr_in,
    input wire logic i_chip_select_n,
    input wire logic i_processor_addr_strobe_n,
    input wire logic i_controller_addr_strobe_n,
    input wire logic i_burst_step_n,
    // write side
    input wire logic i_low_byte_write_n,
    input wire logic i_high_byte_write_n,
    input wire logic [DATA_W-1:0] i_data_io,
    // read side
    input wire logic i_output_enable_n,
    output logic [DATA_W-1:0] o_data_io,
    output logic o_data_io_oe
);

    localparam int BW = sbsr_pkg::BURST_W;

    // lane split and burst counter only serve these sizes
    if (DATA_W != sbsr_pkg::DATA_W || ADDR_W < BW + 1
        || WORDS != (1 << ADDR_W))
    begin : g_size_check
        $error("sbsr_top: unsupported width or depth");
    end

    // storage, no reset: contents are undefined until written
    logic [DATA_W-1:0] mem [WORDS];

    // burst tracking
    logic [ADDR_W-1:0] base_q;
    logic [BW-1:0] count_q;
    logic live_q;

    // first stage: captured request
    logic acc_q;
    logic wr_q;
    logic lo_we_q;
    logic hi_we_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;

    // second stage: output register
    logic [DATA_W-1:0] rdata_q;
    logic rd_valid_q;

    // decoded cycle type
    logic psel;
    logic csel;
    logic desel;
    logic start;
    logic any_we;
    logic [BW-1:0] count_d;
    logic [ADDR_W-1:0] addr_d;

    // committed access of the first stage, a read or a write
    logic do_wr;
    logic do_rd;

    function automatic logic [ADDR_W-1:0] burst_addr(
        input logic [ADDR_W-1:0] base,
        input logic [BW-1:0] cnt
    );
        burst_addr = {base[ADDR_W-1:BW], base[BW-1:0] ^ cnt};
    endfunction : burst_addr

    always_comb
    begin
        // processor strobe counts only when selected
        psel = !i_processor_addr_strobe_n && !i_chip_select_n;
        csel = i_processor_addr_strobe_n && !i_controller_addr_strobe_n
            && !i_chip_select_n;
        // select is looked at only on base loads
        desel = i_chip_select_n && !i_controller_addr_strobe_n;
        // start needs select low, deselect select high: never both
        start = psel || csel;
        any_we = !i_low_byte_write_n || !i_high_byte_write_n;
        do_wr = acc_q && wr_q;
        do_rd = acc_q && !wr_q;
        if (start)
        begin
            count_d = sbsr_pkg::BURST_CNT_RST;
        end
        else if (!i_burst_step_n)
        begin
            // wraps after four accesses
            count_d = count_q + sbsr_pkg::BURST_CNT_STEP;
        end
        else
        begin
            count_d = count_q; // wait state
        end
        if (start)
        begin
            addr_d = burst_addr(i_addr_in, count_d);
        end
        else
        begin
            addr_d = burst_addr(base_q, count_d);
        end
    end

    // burst state
    // count also runs outside a burst; harmless, every start clears it
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            base_q <= sbsr_pkg::ADDR_RST;
            count_q <= sbsr_pkg::BURST_CNT_RST;
            live_q <= 1'b0;
        end
        else if (desel)
        begin
            live_q <= 1'b0;
        end
        else
        begin
            if (start)
            begin
                base_q <= i_addr_in;
                live_q <= 1'b1;
            end
            count_q <= count_d;
        end
    end

    // input registers; the access itself happens one edge later
    // write data is taken every edge but committed only by a write
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            acc_q <= 1'b0;
            wr_q <= 1'b0;
            lo_we_q <= 1'b0;
            hi_we_q <= 1'b0;
            addr_q <= sbsr_pkg::ADDR_RST;
            wdata_q <= sbsr_pkg::DATA_RST;
        end
        else
        begin
            // continue cycles access only inside a live burst
            acc_q <= !desel && (start || live_q);
            // processor strobe start is always a read
            wr_q <= !psel && any_we;
            lo_we_q <= !psel && !i_low_byte_write_n;
            hi_we_q <= !psel && !i_high_byte_write_n;
            addr_q <= addr_d;
            wdata_q <= i_data_io;
        end
    end

    // self-timed write, no external pulse shaping needed
    always_ff @(posedge i_clk)
    begin
        // lanes commit apart so a one-byte write keeps the other lane
        if (do_wr && lo_we_q)
        begin
            mem[addr_q][sbsr_pkg::LOW_LANE_MSB:sbsr_pkg::LOW_LANE_LSB] <=
                wdata_q[sbsr_pkg::LOW_LANE_MSB:sbsr_pkg::LOW_LANE_LSB];
        end
        if (do_wr && hi_we_q)
        begin
            mem[addr_q][sbsr_pkg::HIGH_LANE_MSB:sbsr_pkg::HIGH_LANE_LSB] <=
                wdata_q[sbsr_pkg::HIGH_LANE_MSB:sbsr_pkg::HIGH_LANE_LSB];
        end
    end

    // output register: pipelined read data
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            rdata_q <= sbsr_pkg::DATA_RST;
            rd_valid_q <= 1'b0; // floating from power-up
        end
        else
        begin
            rd_valid_q <= do_rd;
            // data stands between reads, but re-enabling drives it only in the cycle after a read
            if (do_rd)
            begin
                rdata_q <= mem[addr_q];
            end
        end
    end

    assign o_data_io = rdata_q;
    // enable is deliberately not registered so the host can turn the bus
    // around mid-cycle; writes and deselect never drive
    assign o_data_io_oe = rd_valid_q && !i_output_enable_n;

endmodule : sbsr_top

// >>> sim/sbsr_host.sv
// data pin model of the host side of the burst static ram
`timescale 1ns/100ps
module sbsr_host (
    // drivers of the pins
    input wire logic i_drive,
    input wire logic [17:0] i_data,
    input wire logic [17:0] i_dev_data,
    input wire logic i_dev_oe,
    // level seen on the pins
    output logic [17:0] o_bus
);
    // no pull-ups: released pins show inverse of stale data
    assign o_bus = i_dev_oe ? i_dev_data :
        i_drive ? i_data : ~i_data;
endmodule : sbsr_host

// >>> sim/sbsr_top_asserts.sv
// port assertions for the burst static ram
`timescale 1ns/100ps
module sbsr_top_asserts (
    // clock, reset and controls
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_chip_select_n,
    input wire logic i_processor_addr_strobe_n,
    input wire logic i_controller_addr_strobe_n,
    input wire logic i_low_byte_write_n,
    input wire logic i_high_byte_write_n,
    input wire logic i_output_enable_n,
    // read side
    input wire logic [17:0] o_data_io,
    input wire logic o_data_io_oe
);
    wire cs = i_chip_select_n;
    wire ps = i_processor_addr_strobe_n;
    wire cst = i_controller_addr_strobe_n;
    wire g = i_output_enable_n;
    wire oe = o_data_io_oe;
    wire wr = !(i_low_byte_write_n && i_high_byte_write_n);
    wire rdc = !ps || !wr;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    property p_gate; oe |-> !g; endproperty
    property p_prd; !cs && !ps ##2 !g |-> oe; endproperty
    property p_crd; !cs && ps && !cst && !wr ##2 !g |-> oe; endproperty
    property p_desel; cs && !cst |=> ##1 !oe; endproperty
    property p_wfl; ps && wr |=> ##1 !oe; endproperty
    property p_whold; ps && wr |=> ##1 $stable(o_data_io); endproperty
    property p_rst; disable iff (1'h0) i_reset |=> !oe; endproperty
    property p_src; oe |-> $past(rdc, 2); endproperty
    a_gate: assert property (p_gate) else $error("oe gate");
    a_prd: assert property (p_prd) else $error("no read");
    a_crd: assert property (p_crd) else $error("no read");
    a_desel: assert property (p_desel) else $error("desel");
    a_wfl: assert property (p_wfl) else $error("write drive");
    a_whold: assert property (p_whold) else $error("out moved");
    a_rst: assert property (p_rst) else $error("reset drive");
    a_src: assert property (p_src) else $error("no cause");
    c_burst: cover property (!cs && !cst ##1 (ps && cst) [*3]);
    c_desel: cover property (cs && !cst);
    c_wr: cover property (ps && wr ##1 ps && wr);
endmodule : sbsr_top_asserts
bind sbsr_top sbsr_top_asserts chk_u (.i_clk, .i_reset, .i_chip_select_n,
    .i_processor_addr_strobe_n, .i_controller_addr_strobe_n,
    .i_low_byte_write_n, .i_high_byte_write_n, .i_output_enable_n,
    .o_data_io, .o_data_io_oe);

// >>> sim/testbench.sv
// self-checking bench for the burst static ram
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
    $display("unexpected %0t pin mismatch", $time); end end
module testbench;
    localparam logic [14:0] base_a = 15'h5A30;
    logic i_clk = 1'h0, i_reset = 1'h1, hd = 1'h0, live = 1'h0, e1 = 1'h0;
    logic e2 = 1'h0, q_oe;
    logic [6:0] k = 7'h7F, tbl [14] = '{7'h2A, 7'h7A, 7'h7E, 7'h7E, 7'h76,
        7'h76, 7'h76, 7'h76, 7'h56, 7'h76, 7'h36, 7'h40, 7'h66, 7'h66};
    logic [1:0] cnt;
    logic [14:0] a = 15'h0000, bs;
    logic [17:0] d = 18'h00000, d1 = 18'h00000, d2 = 18'h00000, bus, q;
    logic [17:0] mem [int];
    int err_count = 0, total_checks = 0;
    sbsr_top dut_u (.i_clk, .i_reset, .i_addr_in(a), .i_chip_select_n(k[4]),
        .i_processor_addr_strobe_n(k[6]), .i_controller_addr_strobe_n(k[5]),
        .i_burst_step_n(k[3]), .i_low_byte_write_n(k[2]), .i_data_io(bus),
        .i_high_byte_write_n(k[1]), .i_output_enable_n(k[0]), .o_data_io(q),
        .o_data_io_oe(q_oe));
    sbsr_host host_u (.i_drive(hd), .i_data(d), .i_dev_data(q),
        .i_dev_oe(q_oe), .o_bus(bus));
    initial forever #5 i_clk = ~i_clk;
    function automatic logic [14:0] addr_exp(input logic [14:0] b,
        input logic [1:0] n);
        addr_exp = {b[14:2], b[1:0] ^ n};
    endfunction : addr_exp
    function automatic logic [17:0] merge_exp(input logic [17:0] old,
        input logic [17:0] nw, input logic lo_n, input logic hi_n);
        merge_exp = {hi_n ? old[17:9] : nw[17:9], lo_n ? old[8:0] : nw[8:0]};
    endfunction : merge_exp
    task automatic cyc(input logic [6:0] c, input logic [14:0] x,
        input logic [17:0] y);
        logic st, wr;
        logic [14:0] ad;
        st = !c[4] && !(c[6] && c[5]);
        live = st || (live && !(c[4] && !c[5]));
        wr = live && !(st && !c[6]) && !(c[2] && c[1]);
        bs = st ? x : bs;
        cnt = st ? 2'h0 : cnt + 2'(!c[3]);
        ad = addr_exp(bs, cnt);
        if (wr)
            mem[ad] = merge_exp(mem[ad], y, c[2], c[1]);
        @(posedge i_clk);
        {k, a, d, hd} <= {c | {6'h00, wr}, x, y, wr};
        @(negedge i_clk);
        `CHK(q_oe, e2 && !k[0])
        `CHK(q, d2)
        {e2, d2, e1} = {e1, d1, live && !wr};
        d1 = e1 ? mem[ad] : d1;
    endtask : cyc
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    initial
    begin
        #50000 err_count++;
        stop_test();
    end
    initial
    begin
        int r;
        r = $urandom(32'hC11D);
        repeat (16) @(posedge i_clk);
        i_reset <= 1'h0;
        for (int i = 0; i < 430; i++)
        begin
            r = $urandom;
            if (i >= 30)
                cyc({|r[1:0], |r[3:2], &r[5:4], r[8:6], &r[10:9]},
                    base_a + 15'(r[14:11]), 18'(r >> 14));
            else
                cyc(i < 16 ? 7'h40 : tbl[i - 16],
                    base_a + 15'((i * 5 + 1) % 16), 18'(r));
            if (i == 15)
                $display("fill test done");
            if (i == 29)
                $display("corner test done");
        end
        $display("random test done");
        stop_test();
    end
endmodule : testbench
